// file: inc/aui_params.svh
// Timing, offsets and field positions of the line-side transceiver controller
`ifndef AUI_PARAMS_SVH
`define AUI_PARAMS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define AUI_CLK_NS 10
`define AUI_BIT_NS 100
`define AUI_BIT_CYC (`AUI_BIT_NS / `AUI_CLK_NS)
`define AUI_HALF_CYC (`AUI_BIT_CYC / 2)
// Quiet is recognised 1.6 bit times after the last transition, rounded down
`define AUI_QUIET_CYC ((`AUI_BIT_NS * 16) / (10 * `AUI_CLK_NS))
// Quiet is held for at least two bit times
`define AUI_QHOLD_BITS 2
// Edge spacing that separates full-rate from half-rate control symbols
`define AUI_SPLIT_CYC ((`AUI_BIT_CYC * 3) / 4)
// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define AUI_OFS_CTRL 8'h00
`define AUI_OFS_STAT 8'h04
`define AUI_OFS_FRMS 8'h08
`define AUI_CTRL_MON 0
`define AUI_CTRL_SYM 2:1
`define AUI_ST_ACT 0
`define AUI_ST_ISO 1
`define AUI_ST_REQ 2
`define AUI_ST_BAL 3
`define AUI_ST_TXEN 4
`endif

// file: inc/aui_pkg.sv
// Types shared by the line-side transceiver controller
package aui_pkg;
  typedef enum logic [1:0] {aui_sym_quiet, aui_sym_half, aui_sym_full} aui_sym_e;
  typedef logic [7:0] aui_cnt_t;
  typedef struct packed {
    aui_cnt_t cyc;
    logic [1:0] qbits;
    aui_sym_e cur;
    logic lvl;
    aui_cnt_t qrun;
  } aui_gen_s;
  typedef struct packed {
    logic [1:0] do_s1;
    logic [1:0] do_s2;
    logic do_last;
    aui_cnt_t do_gap;
    logic do_active;
    logic [1:0] co_s1;
    logic [1:0] co_s2;
    logic co_last;
    aui_cnt_t co_gap;
    aui_sym_e co_msg;
    logic rx_s1;
    logic rx_s2;
    logic monitor;
    aui_sym_e ci_sel;
    logic bal_err;
    logic [15:0] frames;
    logic tx;
    logic tx_en;
    logic di_a;
    logic di_b;
    logic ci_a;
    logic ci_b;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
    logic [1:0] age;
  } aui_mau_s;
endpackage

// file: hw/aui_symgen.sv
// Control symbol generator: quiet, half-rate and full-rate line symbols
`timescale 1ns/10ps
`default_nettype none
`include "aui_params.svh"
module aui_symgen import aui_pkg::*; #(
  parameter int BIT_CYC = `AUI_BIT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire aui_sym_e sym,
  output logic lvl
);
  localparam aui_cnt_t LAST = aui_cnt_t'(BIT_CYC - 1);
  localparam aui_cnt_t HALF = aui_cnt_t'(BIT_CYC / 2 - 1);
  localparam aui_cnt_t QMIN = aui_cnt_t'(`AUI_QHOLD_BITS * BIT_CYC - 1);
  localparam logic [1:0] QBITS = 2'(`AUI_QHOLD_BITS);

  generate
    if (BIT_CYC < 4 || BIT_CYC > 128 || (BIT_CYC % 2) != 0) begin : g_bad
      $error("aui_symgen: BIT_CYC must be even and within 4..128");
    end
  endgenerate

  aui_gen_s st;
  aui_gen_s next_st;
  logic bnd;
  logic half_pt;
  logic [1:0] nq;

  // ----------------------------------------
  // Bit-cell timing from the local clock
  // ----------------------------------------
  always_comb begin
    next_st = st;
    bnd = st.cyc == LAST;
    half_pt = st.cyc == HALF;
    nq = 2'h0;
    next_st.cyc = bnd ? 8'h00 : st.cyc + 8'h01;
    if (bnd) begin
      if (st.cur == aui_sym_quiet) begin
        nq = (st.qbits == QBITS) ? QBITS : st.qbits + 2'h1;
      end
      // Quiet may only be left once it has lasted its minimum
      if (st.cur == aui_sym_quiet && nq != QBITS) begin
        next_st.cur = aui_sym_quiet;
      end else begin
        next_st.cur = sym;
      end
      if (next_st.cur == aui_sym_quiet) begin
        next_st.lvl = 1'b1;
        next_st.qbits = (st.cur == aui_sym_quiet) ? nq : 2'h0;
      end else begin
        next_st.lvl = ~st.lvl;
        next_st.qbits = 2'h0;
      end
    end else if (half_pt && st.cur == aui_sym_full) begin
      next_st.lvl = ~st.lvl;
    end
    if (next_st.cur == aui_sym_quiet && st.cur == aui_sym_quiet) begin
      next_st.qrun = (st.qrun == 8'hFF) ? st.qrun : st.qrun + 8'h01;
    end else begin
      next_st.qrun = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.lvl <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign lvl = st.lvl;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_full_mid;
    st.cur == aui_sym_full && half_pt;
  endsequence
  sequence seq_half_inner;
    st.cur == aui_sym_half && !bnd;
  endsequence

  chk_quiet_high: assert property (st.cur == aui_sym_quiet |-> st.lvl)
    else $error("quiet symbol not at high level");
  chk_full_toggle: assert property (seq_full_mid |=> $changed(st.lvl))
    else $error("full-rate symbol missed its mid-cell toggle");
  chk_half_steady: assert property (seq_half_inner |=> $stable(st.lvl))
    else $error("half-rate symbol changed inside a bit cell");
  chk_quiet_hold: assert property (
    st.cur == aui_sym_quiet && next_st.cur != aui_sym_quiet |-> st.qrun >= QMIN)
    else $error("quiet left before two bit times");
endmodule
`default_nettype wire

// file: hw/aui_mau_ctrl.sv
// Line-side transceiver controller: decodes terminal pins, drives return pins and medium
// ----------------------------------------
// ----------------------------------------
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "aui_params.svh"
module aui_mau_ctrl import aui_pkg::*; #(
  parameter int BIT_CYC = `AUI_BIT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic data_out_a,
  input wire logic data_out_b,
  input wire logic control_out_a,
  input wire logic control_out_b,
  output logic data_in_a,
  output logic data_in_b,
  output logic control_in_a,
  output logic control_in_b,
  input wire logic medium_rx,
  output logic medium_tx,
  output logic medium_tx_en
);
  localparam aui_cnt_t QUIET_CYC = aui_cnt_t'((`AUI_BIT_NS * 16) * BIT_CYC / (10 * `AUI_BIT_NS));
  localparam aui_cnt_t SPLIT_CYC = aui_cnt_t'((BIT_CYC * 3) / 4);

  generate
    if (BIT_CYC < 4 || BIT_CYC > 128) begin : g_bad
      $error("aui_mau_ctrl: BIT_CYC must lie within 4..128");
    end
  endgenerate

  aui_mau_s st;
  aui_mau_s next_st;
  logic gen_lvl;
  logic do_edge;
  logic co_edge;
  logic acc;

  // ----------------------------------------
  // Control-in symbol source
  // ----------------------------------------
  aui_symgen #(.BIT_CYC(BIT_CYC)) u_ci_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .sym(st.ci_sel),
    .lvl(gen_lvl)
  );

  always_comb begin
    next_st = st;
    next_st.age = (st.age == 2'h3) ? st.age : st.age + 2'h1;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    next_st.do_s1 = {data_out_b, data_out_a};
    next_st.do_s2 = st.do_s1;
    next_st.co_s1 = {control_out_b, control_out_a};
    next_st.co_s2 = st.co_s1;
    next_st.rx_s1 = medium_rx;
    next_st.rx_s2 = st.rx_s1;
    next_st.do_last = st.do_s2[0];
    next_st.co_last = st.co_s2[0];

    // ----------------------------------------
    // Data-out activity detection
    // ----------------------------------------
    do_edge = st.do_s2[0] != st.do_last;
    if (do_edge) begin
      next_st.do_gap = 8'h00;
      if (!st.do_active) begin
        next_st.frames = st.frames + 16'h0001;
      end
      next_st.do_active = 1'b1;
    end else begin
      if (st.do_gap != 8'hFF) begin
        next_st.do_gap = st.do_gap + 8'h01;
      end
      // Inside a frame no gap exceeds one bit time, so this only fires on quiet
      if (st.do_gap >= QUIET_CYC - 8'h01) begin
        next_st.do_active = 1'b0;
      end
    end

    // ----------------------------------------
    // Control-out message decoding
    // ----------------------------------------
    co_edge = st.co_s2[0] != st.co_last;
    if (co_edge) begin
      next_st.co_gap = 8'h00;
      // The first edge after quiet carries no spacing information
      if (st.co_gap < SPLIT_CYC) begin
        next_st.co_msg = aui_sym_full;
      end else if (st.co_gap < QUIET_CYC) begin
        next_st.co_msg = aui_sym_half;
      end
    end else begin
      if (st.co_gap != 8'hFF) begin
        next_st.co_gap = st.co_gap + 8'h01;
      end
      if (st.co_gap >= QUIET_CYC - 8'h01) begin
        next_st.co_msg = aui_sym_quiet;
      end
    end

    // ----------------------------------------
    // Medium and return paths
    // ----------------------------------------
    // Data-out levels go to the medium unchanged, so cell halves keep their order
    next_st.tx = st.do_s2[0];
    // Control symbols never reach the medium; only data-out activity keys it
    next_st.tx_en = st.do_active && !st.monitor && st.co_msg != aui_sym_full;
    // Receive keeps running in either mode
    next_st.di_a = st.rx_s2;
    next_st.di_b = ~st.rx_s2;
    next_st.ci_a = gen_lvl;
    next_st.ci_b = ~gen_lvl;

    // ----------------------------------------
    // Register writes, data phase
    // ----------------------------------------
    if (st.ap_valid && st.ap_write) begin
      case (st.ap_addr)
        `AUI_OFS_CTRL: begin
          next_st.monitor = hwdata[`AUI_CTRL_MON];
          case (hwdata[`AUI_CTRL_SYM])
            2'h1: next_st.ci_sel = aui_sym_half;
            2'h2: next_st.ci_sel = aui_sym_full;
            default: next_st.ci_sel = aui_sym_quiet;
          endcase
        end
        `AUI_OFS_STAT: begin
          if (hwdata[`AUI_ST_BAL]) begin
            next_st.bal_err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A pair fault seen in the clearing cycle is kept
    if (st.do_s2[0] == st.do_s2[1] || st.co_s2[0] == st.co_s2[1]) begin
      next_st.bal_err = 1'b1;
    end

    // ----------------------------------------
    // Address phase and read data
    // ----------------------------------------
    acc = hsel && htrans[1] && hready;
    next_st.ap_valid = acc;
    next_st.ap_write = hwrite;
    next_st.ap_addr = haddr[7:0];
    next_st.rdata = 32'h0000_0000;
    // Read data uses post-write values so a read right after a write sees it
    if (acc && !hwrite) begin
      case (haddr[7:0])
        `AUI_OFS_CTRL: next_st.rdata = {29'h0000_0000, next_st.ci_sel, next_st.monitor};
        `AUI_OFS_STAT: next_st.rdata = {27'h000_0000, st.tx_en, next_st.bal_err,
                                        st.co_msg == aui_sym_half, st.co_msg == aui_sym_full,
                                        st.do_active};
        `AUI_OFS_FRMS: next_st.rdata = {16'h0000, st.frames};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    next_st.rdy = 1'b1;
    next_st.resp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      // Synchronisers start at the idle pair levels, so release shows no false edge or pair fault
      st.do_s1 <= 2'h1;
      st.do_s2 <= 2'h1;
      st.do_last <= 1'b1;
      st.co_s1 <= 2'h1;
      st.co_s2 <= 2'h1;
      st.co_last <= 1'b1;
      st.di_b <= 1'b1;
      st.ci_a <= 1'b1;
      st.rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.rdy;
  assign hresp = st.resp;
  assign hrdata = st.rdata;
  assign data_in_a = st.di_a;
  assign data_in_b = st.di_b;
  assign control_in_a = st.ci_a;
  assign control_in_b = st.ci_b;
  assign medium_tx = st.tx;
  assign medium_tx_en = st.tx_en;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_data_in_pair: assert property (data_in_b == !data_in_a)
    else $error("data-in pair not complementary");
  chk_ctrl_in_pair: assert property (control_in_b == !control_in_a)
    else $error("control-in pair not complementary");
  chk_pair_fault: assert property (st.do_s2[0] == st.do_s2[1] |=> st.bal_err)
    else $error("pair fault not flagged");
  chk_rx_echo: assert property (st.age == 2'h3 |-> data_in_a == $past(medium_rx, 3))
    else $error("medium bit not returned on data-in");
  chk_monitor_txoff: assert property (st.monitor |=> !medium_tx_en)
    else $error("transmitter keyed in monitor mode");
  chk_isolate_txoff: assert property (st.co_msg == aui_sym_full |=> !medium_tx_en)
    else $error("transmitter keyed while isolated");
  chk_quiet_seen: assert property (st.do_gap >= QUIET_CYC |-> !st.do_active)
    else $error("quiet not recognised in time");
  chk_tx_only_data: assert property (medium_tx_en |-> $past(st.do_active))
    else $error("medium keyed without data-out activity");
endmodule
`default_nettype wire

// file: bench/aui_dte_model.sv
// Terminal-side model that drives the Data Out and Control Out pairs
`timescale 1ns/10ps
`default_nettype none
module aui_dte_model #(
  parameter int HALF_NS = 40
) (
  output logic data_out_a,
  output logic data_out_b,
  output logic control_out_a,
  output logic control_out_b
);
  // ----------------------------------------
  // Line state
  // ----------------------------------------
  logic a_lvl = 1'b1;
  logic c_lvl = 1'b1;
  logic pair_break = 1'b0;
  int ctl_mode = 0;
  // The pair fault appears only when a test asks for it
  assign data_out_a = a_lvl;
  assign data_out_b = pair_break ? a_lvl : ~a_lvl;
  assign control_out_a = c_lvl;
  assign control_out_b = ~c_lvl;
  // ----------------------------------------
  // Control Out: 0 normal, 1 availability request, 2 isolate
  // ----------------------------------------
  always begin
    if (ctl_mode == 0) begin
      c_lvl = 1'b1;
      #(HALF_NS);
    end else begin
      c_lvl = ~c_lvl;
      #(ctl_mode == 1 ? 2 * HALF_NS : HALF_NS);
    end
  end
  // ----------------------------------------
  // Data Out: one cell per bit, lsb first, then quiet
  // ----------------------------------------
  task automatic send_frame(input logic [7:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      a_lvl = ~bits[i];
      #(HALF_NS);
      a_lvl = bits[i];
      #(HALF_NS);
    end
    a_lvl = 1'b1;
    #(4 * HALF_NS);
  endtask
endmodule
`default_nettype wire

// file: bench/test_aui_dte_signaling.sv
// Self-checking bench for the line-side transceiver controller
`timescale 1ns/10ps
`default_nettype none
module test_aui_dte_signaling;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic medium_rx = 1'b0;
  logic hreadyout, hresp, medium_tx, medium_tx_en;
  logic [31:0] hrdata;
  logic data_out_a, data_out_b, control_out_a, control_out_b;
  logic data_in_a, data_in_b, control_in_a, control_in_b;
  logic [3:0] rx_h = '0;
  logic [3:0] tx_h = '0;
  logic [3:0] rxc = '0;
  int num_errors = 0;
  int n_compared = 0;
  int frames = 0;
  int ticks = 0;
  int n_tog;
  always #5 hclk = ~hclk;
  aui_mau_ctrl #(.BIT_CYC(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .data_out_a(data_out_a),
    .data_out_b(data_out_b), .control_out_a(control_out_a), .control_out_b(control_out_b),
    .data_in_a(data_in_a), .data_in_b(data_in_b), .control_in_a(control_in_a),
    .control_in_b(control_in_b), .medium_rx(medium_rx), .medium_tx(medium_tx),
    .medium_tx_en(medium_tx_en));
  aui_dte_model dte_u (.data_out_a(data_out_a), .data_out_b(data_out_b),
    .control_out_a(control_out_a), .control_out_b(control_out_b));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check(what, exp, v);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask
  task cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task frame_case(input int m, input logic mon, input logic en);
    dte_u.ctl_mode = m;
    wr(8'h00, {31'h0, mon});
    cycles(40);
    fork
      begin
        #3;
        dte_u.send_frame(8'hA5, 8);
      end
      begin
        cycles(30);
        check("tx_en", {31'h0, en}, {31'h0, medium_tx_en});
        rd_chk(8'h04, {27'h0, en, 1'b0, m == 1, m == 2, 1'b1}, "stat_busy");
      end
    join
    frames++;
    cycles(40);
    rd_chk(8'h04, {29'h0, m == 1, m == 2, 1'b0}, "stat_idle");
    rd_chk(8'h08, frames, "frames");
    dte_u.ctl_mode = 0;
  endtask
  task close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Medium stimulus and pin watchers
  // ----------------------------------------
  always @(posedge hclk) begin
    rxc <= rxc + 4'h1;
    medium_rx <= rxc[1] ^ rxc[3];
  end
  // Data-in and medium_tx lag their source by three clocks
  always @(negedge hclk) begin
    if (!hresetn) begin
      ticks <= 0;
    end else begin
      ticks <= ticks + 1;
      if (ticks > 5) begin
        check("pins", {28'h0, rx_h[2], ~data_in_a, tx_h[2], ~control_in_a},
          {28'h0, data_in_a, data_in_b, medium_tx, control_in_b});
      end
    end
    rx_h <= {rx_h[2:0], medium_rx};
    tx_h <= {tx_h[2:0], data_out_a};
  end
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cycles(2);
    check("rst_pins", 32'h28, {26'h0, hreadyout, hresp, control_in_a, control_in_b, medium_tx,
      medium_tx_en});
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(8'h00, 32'h0, "ctrl_rst");
    rd_chk(8'h04, 32'h0, "stat_rst");
    rd_chk(8'h08, 32'h0, "frms_rst");
    rd_chk(8'h0C, 32'h0, "unmapped");
    wr(8'h0C, 32'hFFFF_FFFF);
    rd_chk(8'h00, 32'h0, "ctrl_alias");
    $display("test reset done");
    frame_case(0, 1'b0, 1'b1);
    frame_case(1, 1'b0, 1'b1);
    frame_case(2, 1'b0, 1'b0);
    frame_case(0, 1'b1, 1'b0);
    $display("test frames done");
    for (int s = 0; s < 3; s++) begin
      wr(8'h00, 32'(s << 1));
      rd_chk(8'h00, 32'(s << 1), "ctrl");
      cycles(40);
      n_tog = 0;
      repeat (40) begin
        @(posedge hclk);
        n_tog += (control_in_a !== control_in_b) ? 0 : 1;
      end
      check("ci_pair", 32'h0, 32'(n_tog));
      n_tog = 0;
      begin
        logic prev;
        prev = control_in_a;
        repeat (40) begin
          @(posedge hclk);
          n_tog += (control_in_a != prev) ? 1 : 0;
          prev = control_in_a;
        end
      end
      check("ci_toggles", 32'(s * 4), 32'(n_tog));
    end
    $display("test control symbols done");
    #3;
    dte_u.pair_break = 1'b1;
    cycles(5);
    #3;
    dte_u.pair_break = 1'b0;
    cycles(5);
    rd_chk(8'h04, 32'h8, "pair_fault");
    wr(8'h04, 32'h8);
    rd_chk(8'h04, 32'h0, "pair_clear");
    $display("test pair fault done");
    close_out();
  end
endmodule
`default_nettype wire
